/* core/ubg_top.sv */
/*
 * Serial channel control: mode registers, baud generator, overrun and
 * stop-bit checks, and the pin multiplexer for operation-stop mode.
 * Assumes the frame datapath and port logic sit outside, on clk_sys,
 * and that all inputs are synchronous to clk_sys.
 */
// Overview of operation
// R1 - Overrun keeps being reported on later receptions until the buffer is read.
// R2 - Receiver checks only the first stop bit, whatever the stop length.
// R3 - Baud control register clears to zero on reset.
// R4 - Software writes the baud control register only as a whole byte.
// R5 - Low nibble k divides the source clock by k plus sixteen.
// R6 - Low nibble all ones passes the source clock, for 3-wire mode only; the divider passes it in every mode, asynchronous included.
// R7 - High nibble picks main clock over two to the n, n one to eleven.
// R8 - Software must not write baud control during a transfer.
// R9 - Internal rate is main clock over two to the n plus one times k plus sixteen.
// R10 - External rate is pin clock over two times k plus sixteen.
// R11 - Channel has stop, asynchronous and 3-wire synchronous modes.
// R12 - In stop mode no transfer; the three pins act as plain ports.
// R13 - Software enters stop mode by clearing sync enable, transmit and receive enables.
// R14 - Sync mode register clears to zero and takes bit or byte writes.
// R15 - Sync mode bit seven enables 3-wire operation.
// R16 - Software writes zero to sync mode bits zero and three to six.
// R17 - Overrun sets when a reception completes before the buffer is read.
// R18 - Divider toggles the baud clock every k plus sixteen source ticks.
// R19 - Writing baud control restarts the divider from zero.
`timescale 1ns/10ps
`default_nettype none
`include "ubg_consts.svh"

module ubg_top
    import ubg_pkg::*;
(
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst, // Async reset, active high
    input wire ubg_pkg::ubg_bus_type bus, // CPU byte access
    output logic [7:0] rdata, // Read data, one cycle after rd
    input wire logic rx_done, // Reception complete pulse
    input wire logic [7:0] rx_data, // Received byte
    input wire logic rx_stop1, // Level of the first stop bit
    input wire logic ser_out_data, // Transmit or shift data
    input wire logic ser_clk_o, // 3-wire clock out
    input wire logic ser_clk_oe_n, // 3-wire clock enable, low drives
    input wire ubg_pkg::ubg_pin_type port_out, // Port drive, data-out pin
    input wire ubg_pkg::ubg_pin_type port_clk, // Port drive, clock pin
    input wire ubg_pkg::ubg_pin_type port_in, // Port drive, data-in pin
    input wire logic serial_in_pin_i, // Data-in pin level
    input wire logic serial_clock_pin_i, // Clock pin level
    output ubg_pkg::ubg_pin_type serial_in_pin, // Data-in pin drive
    output ubg_pkg::ubg_pin_type serial_out_pin, // Data-out pin drive
    output ubg_pkg::ubg_pin_type serial_clock_pin, // Clock pin drive
    output ubg_pkg::ubg_mode_type mode, // Channel mode
    output logic transmit_enable, // Transmitter enabled
    output logic receive_enable, // Receiver enabled
    output logic sync_serial_enable, // 3-wire operation enabled
    output logic stop_length_select, // Two stop bits on transmit
    output logic ser_in, // Serial data to the datapath
    output logic baud_clk, // Baud clock level
    output logic baud_tick // Pulse on baud clock rise, or on every toggle with the pass-through code
);
    import ubg_pkg::*;

    ubg_state_type s_q, s_d;
    logic [3:0] prescale_select;
    logic [3:0] divide_modulus;
    logic [3:0] n_sel;
    logic [`UBG_PS_W-1:0] pre_mask;
    logic int_tick;
    logic ext_tick;
    logic src_tick;
    logic wr_baud;
    logic rd_buf;

    assign prescale_select = s_q.baud_ctrl[7:4];
    assign divide_modulus = s_q.baud_ctrl[3:0];

    // R7 prescale code to n
    always_comb begin
        if (prescale_select == `UBG_PS_N11) begin
            n_sel = `UBG_PS_N_MAX;
        end else if (prescale_select >= `UBG_PS_FIRST && prescale_select <= `UBG_PS_LAST) begin
            n_sel = prescale_select - (`UBG_PS_FIRST - 4'h1);
        end else begin
            n_sel = `UBG_PS_N_MAX; // Prohibited codes fall back to the slowest rate
        end
    end

    // Mask of the low n bits of the prescaler
    genvar gi;
    generate
        for (gi = 0; gi < `UBG_PS_W; gi = gi + 1) begin : g_mask
            assign pre_mask[gi] = (4'(gi) < n_sel);
        end
    endgenerate

    // R9 internal source ticks once per two to the n system clocks
    assign int_tick = ((s_q.pre_cnt & pre_mask) == pre_mask);
    // R10 external source is each rising edge of the clock pin
    assign ext_tick = serial_clock_pin_i & ~s_q.ext_clk_prev;
    assign src_tick = s_q.async_mode[`UBG_CLK_SEL_BIT] ? int_tick : ext_tick;

    // R4 baud control ignores single-bit writes
    assign wr_baud = bus.wr && (bus.addr == `UBG_ADDR_BAUD_CTRL);
    assign rd_buf = bus.rd && (bus.addr == `UBG_ADDR_RX_BUF);

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.ext_clk_prev = serial_clock_pin_i;
        s_d.restart = 1'b0;
        // Free-running prescaler, restarted with the divider
        if (s_q.restart) begin
            s_d.pre_cnt = '0;
        end else begin
            s_d.pre_cnt = s_q.pre_cnt + `UBG_PS_W'(1);
        end

        // Byte writes
        if (bus.wr) begin
            if (bus.addr == `UBG_ADDR_ASYNC_MODE) begin
                s_d.async_mode = bus.wdata;
            end else if (bus.addr == `UBG_ADDR_SYNC_MODE) begin
                // R14 R16 byte write, reserved bits held at zero
                s_d.sync_mode = bus.wdata & `UBG_SYNC_MODE_MASK;
            end else if (wr_baud) begin
                s_d.baud_ctrl = bus.wdata;
                // R19 restart divider
                s_d.restart = 1'b1;
            end
        end

        // Single-bit writes
        if (bus.bit_wr) begin
            if (bus.addr == `UBG_ADDR_ASYNC_MODE) begin
                s_d.async_mode[bus.bit_idx] = bus.bit_val;
            end else if (bus.addr == `UBG_ADDR_SYNC_MODE) begin
                // R14 bit write
                s_d.sync_mode[bus.bit_idx] = bus.bit_val;
                s_d.sync_mode = s_d.sync_mode & `UBG_SYNC_MODE_MASK;
            end
        end

        // Reading the buffer frees it and ends the overrun
        if (rd_buf) begin
            s_d.buf_full = 1'b0;
            s_d.ovr = 1'b0;
        end

        // Reception wins over a read in the same cycle
        if (rx_done && s_q.async_mode[`UBG_RX_EN_BIT]) begin
            s_d.rx_buf = rx_data;
            s_d.buf_full = 1'b1;
            // R17 R1 overrun sets and persists until the buffer is read
            s_d.ovr = (s_q.buf_full && !rd_buf) || (s_q.ovr && !rd_buf);
            // R2 single stop bit check
            s_d.fe = ~rx_stop1;
        end

        // Registered read data
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == `UBG_ADDR_ASYNC_MODE) begin
                s_d.rdata = s_q.async_mode;
            end else if (bus.addr == `UBG_ADDR_ASYNC_STAT) begin
                s_d.rdata = {6'h00, s_q.fe, s_q.ovr};
            end else if (bus.addr == `UBG_ADDR_SYNC_MODE) begin
                s_d.rdata = s_q.sync_mode;
            end else if (bus.addr == `UBG_ADDR_BAUD_CTRL) begin
                s_d.rdata = s_q.baud_ctrl;
            end else if (rd_buf) begin
                s_d.rdata = s_q.rx_buf;
            end
        end

        // R12 pins follow the port logic in stop mode
        if (mode == UBG_MODE_STOP) begin
            s_d.pin_out = port_out;
            s_d.pin_clk = port_clk;
        end else if (mode == UBG_MODE_SYNC) begin
            s_d.pin_out = '{o: ser_out_data, oe_n: 1'b0};
            s_d.pin_clk = '{o: ser_clk_o, oe_n: ser_clk_oe_n};
        end else begin
            // Clock pin is an input in asynchronous mode
            s_d.pin_out = '{o: ser_out_data, oe_n: ~s_q.async_mode[`UBG_TX_EN_BIT]};
            s_d.pin_clk = '{o: 1'b0, oe_n: 1'b1};
        end
    end

    // State register; R3 baud control clears, R14 sync mode clears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.async_mode <= `UBG_RST_ASYNC_MODE;
            s_q.sync_mode <= `UBG_RST_SYNC_MODE;
            s_q.baud_ctrl <= `UBG_RST_BAUD_CTRL;
            s_q.pin_out <= '{o: 1'b0, oe_n: 1'b1};
            s_q.pin_clk <= '{o: 1'b0, oe_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // R5 R18 divider
    ubg_divider u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .src_tick(src_tick),
        .modulus(divide_modulus),
        .restart(s_q.restart),
        .baud_clk(baud_clk),
        .baud_tick(baud_tick)
    );

    // R11 R15 mode decode; sync enable has priority
    always_comb begin
        if (s_q.sync_mode[`UBG_SYNC_EN_BIT]) begin
            mode = UBG_MODE_SYNC;
        end else if (s_q.async_mode[`UBG_TX_EN_BIT] || s_q.async_mode[`UBG_RX_EN_BIT]) begin
            mode = UBG_MODE_UART;
        end else begin
            mode = UBG_MODE_STOP;
        end
    end

    assign sync_serial_enable = s_q.sync_mode[`UBG_SYNC_EN_BIT];
    assign transmit_enable = s_q.async_mode[`UBG_TX_EN_BIT];
    assign receive_enable = s_q.async_mode[`UBG_RX_EN_BIT];
    assign stop_length_select = s_q.async_mode[`UBG_STOP_LEN_BIT];
    // R12 data-in pin is never driven by the channel
    assign serial_in_pin = (mode == UBG_MODE_STOP) ? port_in : ubg_pin_type'{o: 1'b0, oe_n: 1'b1};
    assign serial_out_pin = s_q.pin_out;
    assign serial_clock_pin = s_q.pin_clk;
    // Serial data held idle-high while stopped
    assign ser_in = (mode == UBG_MODE_STOP) ? 1'b1 : serial_in_pin_i;
    assign rdata = s_q.rdata;

endmodule

`default_nettype wire

/* core/ubg_consts.svh */
/*
 * Constants of the serial channel baud generator: register addresses,
 * field positions, reset values and prescaler codes.
 * Assumes a 16-bit byte address space seen by the CPU.
 */
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH

// Byte addresses
`define UBG_ADDR_ASYNC_MODE 16'hff70
`define UBG_ADDR_ASYNC_STAT 16'hff71
`define UBG_ADDR_SYNC_MODE 16'hff72
`define UBG_ADDR_BAUD_CTRL 16'hff73
`define UBG_ADDR_RX_BUF 16'hff74

// Reset values
`define UBG_RST_ASYNC_MODE 8'h00
`define UBG_RST_SYNC_MODE 8'h00
`define UBG_RST_BAUD_CTRL 8'h00

// Field positions
`define UBG_SYNC_EN_BIT 7
`define UBG_TX_EN_BIT 7
`define UBG_RX_EN_BIT 6
`define UBG_STOP_LEN_BIT 2
`define UBG_CLK_SEL_BIT 0
`define UBG_OVR_BIT 0
`define UBG_FE_BIT 1

// Sync mode bits that must read back as zero (0 and 3..6)
`define UBG_SYNC_MODE_MASK 8'h86

// Divider modulus codes
`define UBG_MOD_PASS 4'hf
`define UBG_MOD_BASE 5'h0f

// Prescale codes: 0101..1110 give n = 1..10, 0000 gives n = 11
`define UBG_PS_FIRST 4'h5
`define UBG_PS_LAST 4'he
`define UBG_PS_N11 4'h0
`define UBG_PS_N_MAX 4'hb
`define UBG_PS_W 11

`endif

/* core/ubg_pkg.sv */
/*
 * Types of the serial channel baud generator.
 * Assumes ubg_consts.svh for all numeric constants.
 */
`default_nettype none
`include "ubg_consts.svh"

package ubg_pkg;

    // Channel operating mode
    typedef enum logic [1:0] {
        UBG_MODE_STOP = 2'b00,
        UBG_MODE_UART = 2'b01,
        UBG_MODE_SYNC = 2'b10
    } ubg_mode_type;

    // One pin driven by the block: level and active-low output enable
    typedef struct packed {
        logic o;
        logic oe_n;
    } ubg_pin_type;

    // Byte bus request with single-bit write option
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic bit_wr;
        logic [2:0] bit_idx;
        logic bit_val;
    } ubg_bus_type;

    // Divider state
    typedef struct packed {
        logic [4:0] cnt;
        logic clk;
        logic tick;
    } ubg_div_state_type;

    // Top-level state
    typedef struct packed {
        logic [7:0] async_mode;
        logic [7:0] sync_mode;
        logic [7:0] baud_ctrl;
        logic [7:0] rx_buf;
        logic buf_full;
        logic ovr;
        logic fe;
        logic [7:0] rdata;
        logic [`UBG_PS_W-1:0] pre_cnt;
        logic ext_clk_prev;
        ubg_pin_type pin_out;
        ubg_pin_type pin_clk;
        logic restart;
    } ubg_state_type;

endpackage

`default_nettype wire

/* core/ubg_divider.sv */
/*
 * Five-bit baud divider: toggles the baud clock every k+16 source ticks,
 * or passes the source undivided for the pass-through code.
 * Assumes src_tick is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ubg_consts.svh"

module ubg_divider
    import ubg_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic src_tick, // Source clock pulse
    input wire logic [3:0] modulus, // Value k
    input wire logic restart, // Restart from zero
    output logic baud_clk, // Baud clock level
    output logic baud_tick // Pulse at baud clock rise, or at every toggle with the pass-through code
);
    import ubg_pkg::*;

    ubg_div_state_type s_q, s_d;
    logic [4:0] last;

    // Next state of the divider
    always_comb begin
        last = `UBG_MOD_BASE + {1'b0, modulus};
        s_d = s_q;
        s_d.tick = 1'b0;
        if (restart) begin
            s_d.cnt = 5'h00;
            s_d.clk = 1'b0;
        end else if (src_tick) begin
            // R6 pass through
            if (modulus == `UBG_MOD_PASS) begin
                s_d.clk = ~s_q.clk;
                s_d.tick = 1'b1;
            // R5 R18 divide k+16
            end else if (s_q.cnt == last) begin
                s_d.cnt = 5'h00;
                s_d.clk = ~s_q.clk;
                s_d.tick = ~s_q.clk;
            end else begin
                s_d.cnt = s_q.cnt + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign baud_clk = s_q.clk;
    assign baud_tick = s_q.tick;

endmodule

`default_nettype wire

/* sim/ubg_top_chk.sv */
/* Assertion checker for ubg_top: baud tick, restart, pin mux, mode.
   Assumes it is bound to ubg_top and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
`include "ubg_consts.svh"
module ubg_top_chk
    import ubg_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire ubg_pkg::ubg_bus_type bus, // CPU access
    input wire logic baud_clk, // Baud level
    input wire logic baud_tick, // Baud pulse
    input wire ubg_pkg::ubg_mode_type mode, // Mode
    input wire ubg_pkg::ubg_pin_type port_out, // Port drive
    input wire ubg_pkg::ubg_pin_type port_in, // Port drive
    input wire ubg_pkg::ubg_pin_type serial_out_pin, // Pin drive
    input wire ubg_pkg::ubg_pin_type serial_in_pin, // Pin drive
    input wire logic ser_in, // Data to datapath
    input wire logic serial_in_pin_i, // Pin level
    input wire logic sync_serial_enable, // Sync enable
    input wire logic transmit_enable, // Tx enable
    input wire logic receive_enable // Rx enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Pass-through code of the last baud write; ticks then mark both edges
    logic pass_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pass_q <= 1'b0;
        end else if (bus.wr && bus.addr == `UBG_ADDR_BAUD_CTRL) begin
            pass_q <= (bus.wdata[3:0] == `UBG_MOD_PASS);
        end
    end
    property p_tick_high; baud_tick && !pass_q && !$past(pass_q) |-> baud_clk; endproperty
    a_tick_high: assert property (p_tick_high) else $error("tick while baud low");
    property p_tick_one; baud_tick |=> !baud_tick; endproperty
    a_tick_one: assert property (p_tick_one) else $error("tick too long");
    // Divider holds low for 8 cycles, starting two cycles after a rewrite
    property p_restart;
        bus.wr && bus.addr == `UBG_ADDR_BAUD_CTRL && bus.wdata[3:0] != `UBG_MOD_PASS
            |-> ##2 !baud_clk [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_out_mux; $past(mode) == UBG_MODE_STOP |-> serial_out_pin == $past(port_out);
    endproperty
    a_out_mux: assert property (p_out_mux) else $error("out pin not port");
    property p_in_mux;
        mode == UBG_MODE_STOP ? serial_in_pin == port_in : serial_in_pin.oe_n;
    endproperty
    a_in_mux: assert property (p_in_mux) else $error("in pin drive");
    property p_ser_in; ser_in == (mode == UBG_MODE_STOP ? 1'b1 : serial_in_pin_i); endproperty
    a_ser_in: assert property (p_ser_in) else $error("serial in");
    property p_mode;
        mode == (sync_serial_enable ? UBG_MODE_SYNC :
            (transmit_enable || receive_enable) ? UBG_MODE_UART : UBG_MODE_STOP);
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode");
    property p_sync_bit;
        bus.bit_wr && bus.addr == `UBG_ADDR_SYNC_MODE && bus.bit_idx == 3'h7 && !bus.wr
            |=> sync_serial_enable == $past(bus.bit_val);
    endproperty
    a_sync_bit: assert property (p_sync_bit) else $error("sync enable bit");
endmodule
bind ubg_top ubg_top_chk u_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .baud_clk(baud_clk),
    .baud_tick(baud_tick), .mode(mode), .port_out(port_out), .port_in(port_in),
    .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin), .ser_in(ser_in),
    .serial_in_pin_i(serial_in_pin_i), .sync_serial_enable(sync_serial_enable),
    .transmit_enable(transmit_enable), .receive_enable(receive_enable));
`default_nettype wire

/* sim/ubg_ext_clk.sv */
/* External baud clock source driving the clock pin.
   Assumes clk_sys; the pin stands low whenever run is low. */
`timescale 1ns/10ps
`default_nettype none
module ubg_ext_clk #(parameter int HALF = 2) (
    input wire logic clk_sys, // Clock
    input wire logic run, // Source enable
    output logic pin // Clock pin level
);
    int cnt;
    // Toggle every HALF cycles; idle low so no stray edge reaches the divider
    always @(posedge clk_sys) begin
        if (!run) begin
            pin <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            pin <= ~pin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* sim/testbench.sv */
/* Testbench for ubg_top: registers, baud rates, receive flags, stop mode.
   Assumes ubg_ext_clk as the clock pin source. */
`timescale 1ns/10ps
`default_nettype none
`include "ubg_consts.svh"
module testbench;
    import ubg_pkg::*;
    logic clk_sys, rst, rx_done, rx_stop1, ser_out_data, ser_clk_o, ser_clk_oe_n, pin_i, ext_run;
    logic ext_pin, ser_in, baud_clk, baud_tick, tx_en, rx_en, sync_en, stop_len;
    logic [7:0] rx_data, rdata;
    ubg_bus_type bus;
    ubg_pin_type port_out, port_clk, port_in, in_pin, out_pin, clk_pin;
    ubg_mode_type mode;
    int miscompares, checked;
    ubg_top DUT (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .rx_done(rx_done),
        .rx_data(rx_data), .rx_stop1(rx_stop1), .ser_out_data(ser_out_data),
        .ser_clk_o(ser_clk_o), .ser_clk_oe_n(ser_clk_oe_n), .port_out(port_out),
        .port_clk(port_clk), .port_in(port_in), .serial_in_pin_i(pin_i),
        .serial_clock_pin_i(ext_pin), .serial_in_pin(in_pin), .serial_out_pin(out_pin),
        .serial_clock_pin(clk_pin), .mode(mode), .transmit_enable(tx_en),
        .receive_enable(rx_en), .sync_serial_enable(sync_en), .stop_length_select(stop_len),
        .ser_in(ser_in), .baud_clk(baud_clk), .baud_tick(baud_tick));
    ubg_ext_clk #(.HALF(2)) u_ext (.clk_sys(clk_sys), .run(ext_run), .pin(ext_pin));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Bus cycles: one-cycle strobes, rdata sampled after the following edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic v);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.bit_idx <= i;
        bus.bit_val <= v;
        bus.bit_wr <= 1'b1;
        @(posedge clk_sys);
        bus.bit_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        check("rdata", rdata, e);
    endtask
    task automatic rx(input logic [7:0] d, input logic s);
        @(posedge clk_sys);
        rx_done <= 1'b1;
        rx_data <= d;
        rx_stop1 <= s;
        @(posedge clk_sys);
        rx_done <= 1'b0;
    endtask
    // Cycles between two baud ticks after loading a control byte
    task automatic period(input logic [7:0] bc, input int exp);
        int n;
        wr(`UBG_ADDR_BAUD_CTRL, bc);
        n = 0;
        do begin @(negedge clk_sys); n++; end while (baud_tick !== 1'b1 && n < 5000);
        n = 0;
        do begin @(negedge clk_sys); n++; end while (baud_tick !== 1'b1 && n < 5000);
        check("tick period", n, exp);
    endtask
    task automatic t_regs;
        rd(`UBG_ADDR_BAUD_CTRL, 8'h00);
        rd(`UBG_ADDR_SYNC_MODE, 8'h00);
        bw(`UBG_ADDR_BAUD_CTRL, 3'h0, 1'b1);
        rd(`UBG_ADDR_BAUD_CTRL, 8'h00);
        wr(`UBG_ADDR_SYNC_MODE, 8'h86);
        rd(`UBG_ADDR_SYNC_MODE, 8'h86);
        bw(`UBG_ADDR_SYNC_MODE, 3'h7, 1'b0);
        rd(`UBG_ADDR_SYNC_MODE, 8'h06);
        wr(`UBG_ADDR_SYNC_MODE, 8'h00);
        rd(16'hff7f, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_stop;
        // stop mode needs the enable bits of both registers cleared
        wr(`UBG_ADDR_ASYNC_MODE, 8'h00);
        wr(`UBG_ADDR_SYNC_MODE, 8'h00);
        port_out <= 2'b10;
        port_clk <= 2'b11;
        port_in <= 2'b10;
        ser_clk_o <= 1'b1;
        ser_clk_oe_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("mode", mode, UBG_MODE_STOP);
        check("out pin", out_pin, 2'b10);
        check("clk pin", clk_pin, 2'b11);
        check("in pin", in_pin, 2'b10);
        check("ser in", ser_in, 1'b1);
        bw(`UBG_ADDR_SYNC_MODE, 3'h7, 1'b1);
        #1;
        check("mode", mode, UBG_MODE_SYNC);
        check("sync en", sync_en, 1'b1);
        check("in pin oe", in_pin.oe_n, 1'b1);
        check("ser in", ser_in, 1'b0);
        @(posedge clk_sys);
        #1;
        check("out pin", out_pin, 2'b00);
        check("clk pin", clk_pin, 2'b10);
        wr(`UBG_ADDR_SYNC_MODE, 8'h00);
        ser_clk_oe_n <= 1'b1;
        $display("test stop done");
    endtask
    task automatic t_baud;
        wr(`UBG_ADDR_ASYNC_MODE, 8'hc1);
        period(8'h50, 64);
        period(8'h5e, 120);
        period(8'h60, 128);
        // pass-through only with 3-wire mode on; the divider passes it in every mode
        bw(`UBG_ADDR_SYNC_MODE, 3'h7, 1'b1);
        period(8'h5f, 2);
        bw(`UBG_ADDR_SYNC_MODE, 3'h7, 1'b0);
        wr(`UBG_ADDR_ASYNC_MODE, 8'hc0);
        ext_run <= 1'b1;
        period(8'h02, 144);
        ext_run <= 1'b0;
        $display("test baud done");
    endtask
    task automatic t_recv;
        wr(`UBG_ADDR_ASYNC_MODE, 8'hc5);
        @(posedge clk_sys);
        #1;
        check("enables", {tx_en, rx_en, stop_len}, 3'b111);
        check("out pin", out_pin, 2'b00);
        check("clk pin", clk_pin, 2'b01);
        rx(8'h11, 1'b1);
        rx(8'h22, 1'b1);
        rd(`UBG_ADDR_ASYNC_STAT, 8'h01);
        rx(8'h44, 1'b0);
        rd(`UBG_ADDR_ASYNC_STAT, 8'h03);
        rd(`UBG_ADDR_RX_BUF, 8'h44);
        rd(`UBG_ADDR_ASYNC_STAT, 8'h02);
        rx(8'h55, 1'b1);
        rd(`UBG_ADDR_ASYNC_STAT, 8'h00);
        $display("test recv done");
    endtask
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        miscompares = 0;
        checked = 0;
        rst = 1'b1;
        bus = '0;
        {rx_done, rx_stop1, ser_out_data, ser_clk_o, ser_clk_oe_n, pin_i, ext_run} = 7'h04;
        rx_data = 8'h00;
        port_out = 2'b01;
        port_clk = 2'b01;
        port_in = 2'b01;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_stop();
        t_baud();
        t_recv();
        report_and_stop();
    end
endmodule
`default_nettype wire
